// ---- hdl/fws_host.sv ----
// Host controller that polls flash status flags over APB orders
`timescale 1ns/1ps
`default_nettype none
`include "fws_cfg.svh"

// Behaviour
// - Host polls inside an erasing sector
// - Re-read all bits after polling completes
// - Bad program sets the fail flag; the next start clears it
// - Read window bit around extra commands
module fws_host (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`FWS_DATA_W-1:0] dqIn,
	input wire logic readyBusyPin,
	output logic [`FWS_ADDR_W-1:0] flashAddr,
	output logic ceN,
	output logic oeN,
	output logic weN,
	output logic [`FWS_DATA_W-1:0] dqOut,
	output logic dqOe,
	output logic readyBusyOutput
);
	localparam int P = 7;
	localparam int T = 6;
	localparam int F = 5;
	localparam int W = 3;
	localparam int S = 2;

	fws_pkg::fws_state_t st_q;
	fws_pkg::fws_op_t op_q;
	logic [`FWS_ADDR_W-1:0] addr_q;
	logic [`FWS_DATA_W-1:0] data_q, dq1_q, dq2_q, r1_q, rdat_q;
	logic rb1_q, rb2_q;
	logic busy_q, done_q, fail_q, win_q, stog_q, startCyc_q;
	logic cycDone, cycBusy, cycCe, cycOe;
	logic [`FWS_DATA_W-1:0] cycData;
	logic pace, wrCtrl;

	// Pin synchronisers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dq1_q <= '0;
			dq2_q <= '0;
			rb1_q <= 1'b1;
			rb2_q <= 1'b1;
		end else begin
			dq1_q <= dqIn;
			dq2_q <= dq1_q;
			rb1_q <= readyBusyPin;
			rb2_q <= rb1_q;
		end
	end

	fws_bus_cycle i_fws_bus_cycle (
		.clk(clk),
		.rstn(rstn),
		.start(startCyc_q),
		.dqSync(dq2_q),
		.busy(cycBusy),
		.done(cycDone),
		.rdata(cycData),
		.ceN(cycCe),
		.oeN(cycOe)
	);

	// Zero-wait APB slave
	assign pace = psel && penable;
	assign wrCtrl = pace && pwrite && paddr == `FWS_REG_CTRL;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable) begin
				case (paddr)
					`FWS_REG_CTRL: prdata <= {29'h0, op_q, 1'b0};
					`FWS_REG_ADDR: prdata <= {12'h0, addr_q};
					`FWS_REG_DATA: prdata <= {16'h0, data_q};
					`FWS_REG_STAT: prdata <= {26'h0, rb2_q, stog_q, win_q,
						fail_q, done_q, busy_q};
					`FWS_REG_RDAT: prdata <= {16'h0, rdat_q};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			addr_q <= '0;
			data_q <= '0;
		end else if (pace && pwrite && !busy_q) begin
			if (paddr == `FWS_REG_ADDR)
				addr_q <= pwdata[`FWS_ADDR_W-1:0];
			if (paddr == `FWS_REG_DATA)
				data_q <= pwdata[`FWS_DATA_W-1:0];
		end
	end

	// Poll sequencer: two reads compare toggle bits, final read for data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= fws_pkg::FWS_IDLE;
			op_q <= fws_pkg::FWS_OP_READ;
			startCyc_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			win_q <= 1'b0;
			stog_q <= 1'b0;
			r1_q <= '0;
			rdat_q <= '0;
		end else begin
			startCyc_q <= 1'b0;
			case (st_q)
				fws_pkg::FWS_IDLE: begin
					if (wrCtrl && pwdata[`FWS_CTRL_START]) begin
						op_q <= fws_pkg::fws_op_t'(pwdata[`FWS_CTRL_MODE_HI:
							`FWS_CTRL_MODE_LO]);
						busy_q <= 1'b1;
						done_q <= 1'b0;
						fail_q <= 1'b0;
						startCyc_q <= 1'b1;
						st_q <= fws_pkg::FWS_READ1;
					end
				end
				fws_pkg::FWS_READ1: begin
					if (cycDone) begin
						r1_q <= cycData;
						startCyc_q <= 1'b1;
						st_q <= fws_pkg::FWS_READ2;
					end
				end
				fws_pkg::FWS_READ2: begin
					if (cycDone) begin
						rdat_q <= cycData;
						win_q <= cycData[W];
						stog_q <= cycData[S] ^ r1_q[S];
						st_q <= fws_pkg::FWS_EVAL;
					end
				end
				fws_pkg::FWS_EVAL: begin
					st_q <= fws_pkg::FWS_READ1;
					startCyc_q <= 1'b1;
					case (op_q)
						fws_pkg::FWS_OP_READ: begin
							st_q <= fws_pkg::FWS_DONE;
							startCyc_q <= 1'b0;
						end
						fws_pkg::FWS_OP_PROG_POLL: begin
							if (rdat_q[P] == data_q[P])
								st_q <= fws_pkg::FWS_FINAL;
							else if (rdat_q[F])
								st_q <= fws_pkg::FWS_FINAL;
						end
						fws_pkg::FWS_OP_ERASE_POLL: begin
							if (rdat_q[P] || rdat_q[F])
								st_q <= fws_pkg::FWS_FINAL;
						end
						default: begin
							if (rdat_q[T] == r1_q[T] || rdat_q[F])
								st_q <= fws_pkg::FWS_FINAL;
						end
					endcase
				end
				fws_pkg::FWS_FINAL: begin
					if (cycDone) begin
						rdat_q <= cycData;
						if (op_q == fws_pkg::FWS_OP_PROG_POLL)
							fail_q <= cycData[P] != data_q[P];
						else if (op_q == fws_pkg::FWS_OP_ERASE_POLL)
							fail_q <= !cycData[P];
						else
							fail_q <= cycData[T] != r1_q[T];
						st_q <= fws_pkg::FWS_DONE;
					end
				end
				fws_pkg::FWS_DONE: begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					st_q <= fws_pkg::FWS_IDLE;
				end
				default: st_q <= fws_pkg::FWS_IDLE;
			endcase
		end
	end

	// Flash pins, all registered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flashAddr <= '0;
			ceN <= 1'b1;
			oeN <= 1'b1;
			weN <= 1'b1;
			dqOut <= '0;
			dqOe <= 1'b0;
			readyBusyOutput <= 1'b1;
		end else begin
			flashAddr <= addr_q;
			ceN <= cycCe;
			oeN <= cycOe;
			weN <= 1'b1;
			dqOut <= '0;
			dqOe <= 1'b0;
			readyBusyOutput <= rb2_q;
		end
	end

	logic unusedBusy;
	assign unusedBusy = cycBusy;
endmodule : fws_host
`default_nettype wire

// ---- hdl/fws_cfg.svh ----
// Constants for the flash status controller
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH

`define FWS_REG_CTRL 8'h00
`define FWS_REG_ADDR 8'h04
`define FWS_REG_DATA 8'h08
`define FWS_REG_STAT 8'h0c
`define FWS_REG_RDAT 8'h10

`define FWS_CTRL_START 0
`define FWS_CTRL_MODE_LO 1
`define FWS_CTRL_MODE_HI 2

`define FWS_STAT_BUSY 0
`define FWS_STAT_DONE 1
`define FWS_STAT_FAIL 2
`define FWS_STAT_WIN 3
`define FWS_STAT_STOG 4
`define FWS_STAT_RDY 5

`define FWS_ADDR_W 20
`define FWS_DATA_W 16

`define FWS_BUS_NS 40
`define FWS_BUS_CYC ((`FWS_BUS_NS + 3) / 4)

`endif

// ---- hdl/fws_pkg.sv ----
// Types for the flash status controller
`default_nettype none
package fws_pkg;
	typedef enum logic [1:0] {
		FWS_OP_READ,
		FWS_OP_PROG_POLL,
		FWS_OP_ERASE_POLL,
		FWS_OP_TOGGLE_POLL
	} fws_op_t;
	typedef enum logic [2:0] {
		FWS_IDLE,
		FWS_READ1,
		FWS_READ2,
		FWS_EVAL,
		FWS_FINAL,
		FWS_DONE
	} fws_state_t;
endpackage : fws_pkg
`default_nettype wire

// ---- hdl/fws_bus_cycle.sv ----
// One timed read cycle on the flash parallel bus
`timescale 1ns/1ps
`default_nettype none
`include "fws_cfg.svh"

module fws_bus_cycle (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [`FWS_DATA_W-1:0] dqSync,
	output logic busy,
	output logic done,
	output logic [`FWS_DATA_W-1:0] rdata,
	output logic ceN,
	output logic oeN
);
	logic [7:0] cnt_q;
	logic [1:0] phase_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 8'h00;
			phase_q <= 2'h0;
			done <= 1'b0;
			ceN <= 1'b1;
			oeN <= 1'b1;
			rdata <= '0;
		end else begin
			done <= 1'b0;
			case (phase_q)
				2'h0: begin
					if (start) begin
						ceN <= 1'b0;
						oeN <= 1'b0;
						cnt_q <= 8'(`FWS_BUS_CYC + 2);
						phase_q <= 2'h1;
					end
				end
				2'h1: begin
					if (cnt_q == 8'h00) begin
						rdata <= dqSync;
						ceN <= 1'b1;
						oeN <= 1'b1;
						cnt_q <= 8'(`FWS_BUS_CYC);
						phase_q <= 2'h2;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				2'h2: begin
					if (cnt_q == 8'h00) begin
						done <= 1'b1;
						phase_q <= 2'h0;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				default: phase_q <= 2'h0;
			endcase
		end
	end

	assign busy = (phase_q != 2'h0);
endmodule : fws_bus_cycle
`default_nettype wire

// ---- tb/fws_host_monitor.sv ----
// Port checker for the flash status host
`timescale 1ns/1ps
`default_nettype none
module fws_host_monitor (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [19:0] flashAddr,
	input wire logic ceN,
	input wire logic oeN,
	input wire logic [15:0] dqOut,
	input wire logic weN,
	input wire logic dqOe,
	input wire logic readyBusyPin,
	input wire logic readyBusyOutput
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_ready_in_access: assert property (psel && !penable |=> pready)
		else $error("no pready");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("lone pslverr");
	a_never_drives: assert property (weN && !dqOe && dqOut == 16'h0000)
		else $error("flash bus driven");
	a_ce_with_oe: assert property (ceN == oeN)
		else $error("strobes apart");
	a_addr_held: assert property (!oeN |-> $stable(flashAddr))
		else $error("address moved");
	a_read_width: assert property ($fell(oeN) |-> !oeN [*8])
		else $error("short read");
	a_read_gap: assert property ($rose(oeN) |-> oeN [*8])
		else $error("short gap");
	a_rb_follows: assert property ($changed(readyBusyPin) |->
		##[1:4] readyBusyOutput == readyBusyPin)
		else $error("ready copy late");
	c_err: cover property (pslverr);
	c_read: cover property ($fell(oeN));
	c_busy: cover property ($fell(readyBusyOutput));
endmodule : fws_host_monitor
bind fws_host fws_host_monitor i_mon (.clk(clk), .rstn(rstn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.flashAddr(flashAddr), .ceN(ceN), .oeN(oeN), .dqOut(dqOut),
	.weN(weN), .dqOe(dqOe),
	.readyBusyPin(readyBusyPin), .readyBusyOutput(readyBusyOutput));
`default_nettype wire

// ---- tb/fws_flash_model.sv ----
// Behavioural flash that answers reads with status flags
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model (
	input wire logic ceN,
	input wire logic oeN,
	input wire logic [1:0] op,
	input wire logic [15:0] data,
	output logic [15:0] dq,
	output logic rb
);
	int left = 0;
	logic tog = 1'b0;
	logic [15:0] last = 16'h0000;
	logic rd, busy;
	logic [15:0] word;
	assign rd = !ceN && !oeN;
	assign busy = op != 2'h0 && (left > 0 || op == 2'h3);
	assign word = !busy ? data : {8'h00,
		op[0] ? ~data[7] : 1'b0, tog, op == 2'h3 && left == 0,
		1'b0, op == 2'h2, op == 2'h2 && tog, 2'h0};
	// Released bus shows the inverse, never the last word
	assign dq = rd ? word : ~last;
	assign rb = !busy;
	always @(posedge rd) tog <= ~tog;
	always @(negedge rd) begin
		last = word;
		if (left > 0) left = left - 1;
	end
endmodule : fws_flash_model
`default_nettype wire

// ---- tb/tb_fws_host.sv ----
// Self-checking bench for the flash status host
`timescale 1ns/1ps
`default_nettype none
module tb_fws_host;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, ceN, oeN, weN, dqOe, ev, rbPin, rbOut;
	logic [15:0] dqIn, dqOut;
	logic [19:0] flashAddr;
	logic [1:0] op = 2'h0;
	logic [15:0] fdata = 16'h0000;
	int errCount = 0;
	int nCompared = 0;
	fws_host i_fws_host (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dqIn(dqIn),
		.readyBusyPin(rbPin), .flashAddr(flashAddr), .ceN(ceN), .oeN(oeN),
		.weN(weN), .dqOut(dqOut), .dqOe(dqOe), .readyBusyOutput(rbOut));
	fws_flash_model i_fws_flash_model (.ceN(ceN), .oeN(oeN), .op(op),
		.data(fdata), .dq(dqIn), .rb(rbPin));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic check(input string nm, input logic [31:0] s, x);
		nCompared++;
		if (s !== x) begin
			errCount++;
			$display("BAD %s expected %h seen %h", nm, x, s);
		end
	endtask : check
	task automatic run(input logic [1:0] md, fop, input int n,
		input logic [15:0] fd, input logic [5:0] m, x);
		int k;
		op <= fop;
		fdata <= fd;
		i_fws_flash_model.left = n;
		apb(1'b1, 8'h04, 32'h00001000);
		apb(1'b1, 8'h08, {16'h0, fd});
		apb(1'b1, 8'h00, {29'h0, md, 1'b1});
		// Refused while busy
		apb(1'b1, 8'h04, 32'h00000bad);
		k = 0;
		do begin
			apb(1'b0, 8'h0c, 32'h0);
			k++;
		end while (rv[1] !== 1'b1 && k < 400);
		check("stat", {26'h0, rv[5:0] & m}, {26'h0, x});
		apb(1'b0, 8'h04, 32'h0);
		check("addr", rv, 32'h00001000);
		check("pin addr", {12'h0, flashAddr}, 32'h00001000);
		apb(1'b0, 8'h00, 32'h0);
		check("mode", {30'h0, rv[2:1]}, {30'h0, md});
		apb(1'b0, 8'h10, 32'h0);
		if (!x[2]) check("rdat", rv, {16'h0, fd});
	endtask : run
	task automatic finalReport;
		$display("compared %0d mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finalReport
	initial begin
		#200000;
		errCount++;
		finalReport;
	end
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, 8'h0c, 32'h0);
		check("reset stat", {26'h0, rv[5:0] & 6'h23}, 32'h20);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped", {31'h0, ev}, 32'h1);
		run(2'h1, 2'h1, 5, 16'h00a5, 6'h2f, 6'h22);
		run(2'h2, 2'h2, 5, 16'hffff, 6'h3f, 6'h3a);
		run(2'h3, 2'h1, 4, 16'h1234, 6'h27, 6'h22);
		run(2'h1, 2'h3, 3, 16'h00a5, 6'h27, 6'h06);
		run(2'h0, 2'h0, 0, 16'h5a5a, 6'h27, 6'h22);
		finalReport;
	end
endmodule : tb_fws_host
`default_nettype wire
